// [sae_pkg.sv]
// Package: shared constants and carrier types of the spectrum averaging engine
package sae_pkg;
    localparam int REC_LEN      = 1024;        // Samples per time record
    localparam int FFT_OUT      = 512;         // Complex values from one transform
    localparam int BIN_CNT      = 256;         // Bins kept, lowest ones only
    localparam int SAMP_W       = 16;
    localparam int ACC_W        = 48;
    localparam int KSEL_W       = 3;
    localparam logic [KSEL_W-1:0] KSEL_MIN = 3'h0;  // Code 0 means K = 4
    localparam logic [KSEL_W-1:0] KSEL_MAX = 3'h6;  // Code 6 means K = 256
    localparam int KLOG_BASE    = 2;           // log2 of the smallest K
    localparam int FIFO_DEPTH   = 32;
    localparam int EXP_NEW_SH   = 2;           // New spectrum weighted by 1/4
    localparam int EXP_OLD_MUL  = 3;           // Previous average weighted by 3/4

    typedef enum logic [1:0] {
        SAE_MODE_POWER,
        SAE_MODE_EXP,
        SAE_MODE_TIME
    } sae_mode_t;

    // One complex transform output value
    typedef struct packed {
        logic signed [SAMP_W-1:0] re;
        logic signed [SAMP_W-1:0] im;
    } sae_cplx_t;

    // One displayed bin
    typedef struct packed {
        logic [7:0]        bin;
        logic [SAMP_W-1:0] value;
        logic              last;
    } sae_out_t;
endpackage : sae_pkg

// [sae_fifo.sv]
// Module: parameterised valid/ready FIFO in the display data path
module sae_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // Storage array, written only when not full
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : sae_fifo

// [sae_engine.sv]
// Module: spectrum averaging engine with capture, averaging and display output
// Summary of operation
// RQ1: Single-channel capture stores each record as 1024 samples before transforming.
// RQ2: Of 512 complex transform values only the lowest 256 are kept.
// RQ3: 256 bin locations hold linear or log magnitude per a select input.
// RQ4: Bin power is the squared magnitude, value times its conjugate.
// RQ5: Displayed value is amplitude, the square root of bin power; time mode shows the square root of K times bin power.
// RQ6: Power mode averages each bin's power over K successive records.
// RQ7: Time mode sums K aligned records sample by sample, divides by K.
// RQ8: Each time-averaged record starts on the external synchronizing pulse.
// RQ9: K for time averaging never exceeds 256 records.
// RQ10: Operator should run time averaging then power averaging for both gains.
// RQ11: K selectable only as power of two, 4 to 256.
// RQ12: Exponential mode: new bin is quarter latest plus three quarters previous.
// RQ13: Division by K is an arithmetic right shift by log2 K.
module sae_engine
    import sae_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     start,
    input  wire sae_pkg::sae_mode_t       mode,
    input  wire logic [sae_pkg::KSEL_W-1:0] k_sel,
    input  wire logic                     log_sel,
    input  wire logic                     sync_in,
    input  wire logic signed [sae_pkg::SAMP_W-1:0] samp_in,
    input  wire logic                     samp_valid,
    output logic signed [sae_pkg::SAMP_W-1:0] fft_samp,
    output logic [9:0]                    fft_addr,
    output logic                          fft_valid,
    output logic                          fft_start,
    input  wire sae_pkg::sae_cplx_t       fft_in,
    input  wire logic                     fft_in_valid,
    output sae_pkg::sae_out_t             disp_data,
    output logic                          disp_valid,
    input  wire logic                     disp_ready,
    output logic                          busy,
    output logic                          done
);
    import sae_pkg::*;

    typedef enum logic [2:0] {
        SAE_IDLE, SAE_WAIT_SYNC, SAE_CAPTURE, SAE_SEND, SAE_SPEC, SAE_OUT
    } sae_state_t;

    // Index widths follow the record, transform and bin counts
    localparam int RA_W = $clog2(REC_LEN);
    localparam int BA_W = $clog2(BIN_CNT);
    localparam int FA_W = $clog2(FFT_OUT);
    localparam int OUT_W = BA_W + SAMP_W + 1;

    sae_state_t              state;
    logic [RA_W-1:0]         cap_idx;
    logic [RA_W-1:0]         send_idx;
    logic [FA_W-1:0]         spec_idx;
    logic [BA_W-1:0]         out_idx;
    logic [8:0]              rec_cnt;
    logic [KSEL_W-1:0]       k_code;
    sae_mode_t               mode_q;
    logic signed [ACC_W-1:0] tacc [REC_LEN];   // Time-domain sums
    logic [ACC_W-1:0]        pacc [BIN_CNT];   // Per-bin power sums
    logic [2*SAMP_W:0]       pwr;
    logic [ACC_W-1:0]        avg_val;
    logic [SAMP_W-1:0]       amp;
    logic [SAMP_W-1:0]       disp_val;
    logic                    fifo_ready;
    logic                    out_fire;
    logic [OUT_W-1:0]        fifo_out;
    logic                    fifo_ovalid;
    logic [8:0]              k_val;
    logic [3:0]              k_shift;
    logic                    stop_req;         // Moving average asked to stop

    // Clamp the K code to the legal range 4..256
    function automatic logic [KSEL_W-1:0] clamp_k(input logic [KSEL_W-1:0] c);
        clamp_k = (c > KSEL_MAX) ? KSEL_MAX : c;   // RQ11 RQ9
    endfunction : clamp_k

    // Integer square root, bit-serial restoring, combinational
    // Sixteen unrolled trial squares: a long path, accepted for one bin a cycle
    function automatic logic [SAMP_W-1:0] isqrt(input logic [ACC_W-1:0] v);
        logic [ACC_W-1:0]  rem;
        logic [SAMP_W-1:0] root;
        logic [ACC_W-1:0]  trial;
        rem  = v;
        root = '0;
        for (int b = SAMP_W - 1; b >= 0; b--) begin
            trial = ACC_W'(({root | (SAMP_W'(1) << b)}) * ({root | (SAMP_W'(1) << b)}));
            if (trial <= v) begin
                root = root | (SAMP_W'(1) << b);
            end
        end
        isqrt = root;
    endfunction : isqrt

    // Log magnitude as position of leading one with three fraction bits
    // A zero amplitude gives code zero, the same as an amplitude of one
    function automatic logic [SAMP_W-1:0] log_mag(input logic [SAMP_W-1:0] a);
        logic [SAMP_W-1:0] r;
        r = '0;
        for (int b = 0; b < SAMP_W; b++) begin
            if (a[b]) begin
                r = SAMP_W'(b * 8) | SAMP_W'((b >= 3) ? ((a >> (b - 3)) & 16'h0007) : 16'h0000);
            end
        end
        log_mag = r;
    endfunction : log_mag

    // K is four shifted left by the code
    assign k_shift = 4'(KLOG_BASE) + 4'(k_code);
    assign k_val   = 9'(1) << k_shift;
    // Squared magnitude, re*re + im*im
    assign pwr = (2*SAMP_W+1)'(fft_in.re * fft_in.re)
               + (2*SAMP_W+1)'(fft_in.im * fft_in.im);   // RQ4
    // Divide by K with a shift in power mode; exponential and time modes use the stored value directly
    // Interim power averages read low until all K passes have been summed
    assign avg_val = (mode_q == SAE_MODE_POWER) ? (pacc[out_idx] >> k_shift)
                                                : pacc[out_idx];  // RQ6 RQ13
    assign amp      = isqrt(avg_val);                        // RQ5
    assign disp_val = log_sel ? log_mag(amp) : amp;          // RQ3
    assign out_fire = (state == SAE_OUT) && fifo_ready;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    // Power mode loops K passes, moving average loops until stopped,
    // time mode loops captures only and transforms once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state    <= SAE_IDLE;
            cap_idx  <= '0;
            send_idx <= '0;
            spec_idx <= '0;
            out_idx  <= '0;
            rec_cnt  <= '0;
            k_code   <= KSEL_MIN;
            mode_q   <= SAE_MODE_POWER;
            done     <= 1'b0;
            busy     <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                SAE_IDLE: begin
                    if (start) begin
                        // K and mode stay frozen for the whole run
                        k_code  <= clamp_k(k_sel);
                        // Time averaging has no exponential variant
                        mode_q  <= mode;
                        rec_cnt <= '0;
                        busy    <= 1'b1;
                        state   <= (mode == SAE_MODE_TIME) ? SAE_WAIT_SYNC : SAE_CAPTURE;
                    end
                end
                SAE_WAIT_SYNC: begin
                    // Record alignment to the periodic component
                    if (sync_in) begin
                        state <= SAE_CAPTURE;      // RQ8
                    end
                end
                SAE_CAPTURE: begin
                    if (samp_valid) begin
                        cap_idx <= cap_idx + 1'b1;
                        if (cap_idx == RA_W'(REC_LEN - 1)) begin   // RQ1
                            // Moving average count stops at two; wrapping would reload it
                            if (mode_q != SAE_MODE_EXP || rec_cnt != 9'h002) begin
                                rec_cnt <= rec_cnt + 1'b1;
                            end
                            if (mode_q != SAE_MODE_TIME) begin
                                state <= SAE_SEND;
                            end else if (rec_cnt + 1'b1 == k_val) begin
                                state <= SAE_SEND;
                            end else begin
                                state <= SAE_WAIT_SYNC;
                            end
                        end
                    end
                end
                SAE_SEND: begin
                    // Words stream back to back, one per clock
                    send_idx <= send_idx + 1'b1;
                    if (send_idx == RA_W'(REC_LEN - 1)) begin
                        spec_idx <= '0;
                        state    <= SAE_SPEC;
                    end
                end
                SAE_SPEC: begin
                    // Upper half is counted through but never stored
                    if (fft_in_valid) begin
                        spec_idx <= spec_idx + 1'b1;
                        if (spec_idx == FA_W'(FFT_OUT - 1)) begin
                            out_idx <= '0;
                            state   <= SAE_OUT;
                        end
                    end
                end
                SAE_OUT: begin
                    if (out_fire) begin
                        out_idx <= out_idx + 1'b1;
                        if (out_idx == BA_W'(BIN_CNT - 1)) begin
                            if (mode_q == SAE_MODE_POWER && rec_cnt != k_val) begin
                                state <= SAE_CAPTURE;
                            end else if (mode_q == SAE_MODE_EXP && !start && !stop_req) begin
                                // Moving average runs until start pulses again
                                state <= SAE_CAPTURE;
                            end else begin
                                busy  <= 1'b0;
                                done  <= 1'b1;
                                state <= SAE_IDLE;
                            end
                        end
                    end
                end
                default: state <= SAE_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-domain accumulator; first record overwrites, later ones add in time mode only
    // No reset needed: a run's first record always overwrites every word
    always_ff @(posedge clk) begin
        if (state == SAE_CAPTURE && samp_valid) begin
            if (mode_q != SAE_MODE_TIME || rec_cnt == '0) begin
                tacc[cap_idx] <= ACC_W'(samp_in);
            end else begin
                tacc[cap_idx] <= tacc[cap_idx] + ACC_W'(samp_in);   // RQ7
            end
        end
    end

    // Stop request for the moving average; a start pulse seen at any point
    // of a pass is kept, since a pulse rarely lands on the closing bin itself
    always_ff @(posedge clk) begin
        if (sys_rst || state == SAE_IDLE) begin
            stop_req <= 1'b0;
        end else if (start && mode_q == SAE_MODE_EXP) begin
            stop_req <= 1'b1;
        end
    end

    // Record to the transform; time mode sends the sum shifted by log2 K
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fft_valid <= 1'b0;
            fft_start <= 1'b0;
            fft_addr  <= '0;
            fft_samp  <= '0;
        end else begin
            fft_valid <= (state == SAE_SEND);
            fft_start <= (state == SAE_SEND) && (send_idx == '0);
            fft_addr  <= send_idx;
            fft_samp  <= (mode_q == SAE_MODE_TIME)
                       ? SAMP_W'(tacc[send_idx] >>> k_shift)    // RQ7 RQ13
                       : SAMP_W'(tacc[send_idx]);
        end
    end

    // Per-bin power: lowest 256 of 512 kept, upper half dropped
    // Sums keep full width: 48 bits hold 256 squared 16-bit magnitudes
    always_ff @(posedge clk) begin
        if (state == SAE_SPEC && fft_in_valid && spec_idx < FA_W'(BIN_CNT)) begin   // RQ2
            if (mode_q == SAE_MODE_EXP) begin
                pacc[BA_W'(spec_idx)] <= (rec_cnt == 9'h001)
                    ? ACC_W'(pwr)
                    : ((ACC_W'(pwr) + EXP_OLD_MUL * pacc[BA_W'(spec_idx)])
                       >> EXP_NEW_SH);                                    // RQ12
            end else if (mode_q == SAE_MODE_POWER && rec_cnt != 9'h001) begin
                pacc[BA_W'(spec_idx)] <= pacc[BA_W'(spec_idx)] + ACC_W'(pwr);   // RQ6
            end else begin
                // Time mode shows one spectrum of the averaged record
                pacc[BA_W'(spec_idx)] <= (mode_q == SAE_MODE_TIME)
                    ? (ACC_W'(pwr) << k_shift) : ACC_W'(pwr);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display FIFO; a stalled display stalls bin output
    // Bins wait in the output state while the FIFO is full
    sae_fifo #(
        .WIDTH (OUT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   ({out_idx, disp_val, (out_idx == BA_W'(BIN_CNT - 1))}),
        .in_valid  (state == SAE_OUT),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_ovalid),
        .out_ready (!disp_valid || disp_ready)
    );

    // Registered display stage
    // Keeps the display port straight from flip-flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            disp_valid <= 1'b0;
            disp_data  <= '0;
        end else if (!disp_valid || disp_ready) begin
            disp_valid <= fifo_ovalid;
            disp_data  <= fifo_out;
        end
    end
endmodule : sae_engine

// [sae_chk.sv]
// Checker: port-level assertions of the spectrum averaging engine
module sae_chk
    import sae_pkg::*;
(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               start,
    input wire logic [9:0]         fft_addr,
    input wire logic               fft_valid,
    input wire logic               fft_start,
    input wire sae_pkg::sae_out_t  disp_data,
    input wire logic               disp_valid,
    input wire logic               disp_ready,
    input wire logic               busy,
    input wire logic               done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] prev_bin;
    logic       have_bin;
    ////////////////////////////////////////
    // Last accepted bin; cleared by reset so each run starts from bin 0
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            have_bin <= 1'b0;
        end else if (disp_valid && disp_ready) begin
            have_bin <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (disp_valid && disp_ready) begin
            prev_bin <= disp_data.bin;
        end
    end
    chk_word_zero: assert property (fft_start |-> fft_valid && fft_addr == 10'h000)
        else $error("record start not on word zero");
    chk_fft_burst: assert property (fft_start |=> fft_valid [*8])
        else $error("record burst broken");
    chk_addr_step: assert property (fft_valid && fft_addr != 10'h3FF
        |=> fft_valid && fft_addr == $past(fft_addr) + 10'h001)
        else $error("record address did not step");
    chk_last_bin: assert property (disp_valid |-> disp_data.last == (disp_data.bin == 8'hFF))
        else $error("last flag not on bin 255");
    chk_bin_order: assert property (disp_valid
        |-> disp_data.bin == (have_bin ? prev_bin + 8'h01 : 8'h00))
        else $error("bins out of order");
    chk_disp_hold: assert property (disp_valid && !disp_ready |=> disp_valid && $stable(disp_data))
        else $error("display word dropped while stalled");
    chk_done_pulse: assert property (done |=> !done && !busy)
        else $error("done not a single pulse ending the run");
    chk_start_busy: assert property (start && !busy |=> busy)
        else $error("start did not begin a run");
    chk_idle_quiet: assert property (!busy |-> !fft_valid)
        else $error("record sent while idle");
endmodule : sae_chk

bind sae_engine sae_chk u_chk (.clk(clk), .sys_rst(sys_rst), .start(start),
    .fft_addr(fft_addr), .fft_valid(fft_valid), .fft_start(fft_start),
    .disp_data(disp_data), .disp_valid(disp_valid), .disp_ready(disp_ready),
    .busy(busy), .done(done));

// [sae_fe_model.sv]
// Partner model: sample front end with a periodic synchronizing pulse
module sae_fe_model
    import sae_pkg::*;
(
    input wire logic                          clk,
    input wire logic                          sys_rst,
    output logic                              sync_in,
    output logic signed [sae_pkg::SAMP_W-1:0] samp_in,
    output logic                              samp_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FRAME = 1100;
    int         pos;
    logic [1:0] rec;
    ////////////////////////////////////////
    // Frame position; record number wraps every four frames
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pos <= 0;
            rec <= 2'h0;
        end else begin
            pos <= (pos == FRAME - 1) ? 0 : pos + 1;
            rec <= (pos == FRAME - 1) ? rec + 2'h1 : rec;
        end
    end
    // Sync one cycle before each record, always at the same signal phase
    assign sync_in    = (pos == 49);
    assign samp_valid = 1'b1;
    // Word j is rec - j; outside records a moving pattern that time mode must skip
    assign samp_in = (pos >= 50 && pos < 1074) ? 16'(int'(rec) - (pos - 50))
                                               : 16'(16'h7000 + pos);
endmodule : sae_fe_model

// [tb.sv]
// Testbench: time, power and exponential runs against the front-end model
module tb;
    import sae_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, start, log_sel, sync_in, samp_valid, fft_valid, fft_start;
    logic fft_in_valid, disp_valid, disp_ready, busy, done, chk_time;
    sae_mode_t mode;
    logic [2:0] k_sel;
    logic signed [15:0] samp_in, fft_samp;
    logic [9:0] fft_addr;
    logic [15:0] re_k, im_k;
    sae_cplx_t fft_in;
    sae_out_t disp_data, got[$];
    int err_total = 0, num_checks = 0, n_done = 0, n_fft = 0, cyc = 0;

    sae_engine dut (.clk(clk), .sys_rst(sys_rst), .start(start), .mode(mode), .k_sel(k_sel),
        .log_sel(log_sel), .sync_in(sync_in), .samp_in(samp_in), .samp_valid(samp_valid),
        .fft_samp(fft_samp), .fft_addr(fft_addr), .fft_valid(fft_valid),
        .fft_start(fft_start), .fft_in(fft_in), .fft_in_valid(fft_in_valid),
        .disp_data(disp_data), .disp_valid(disp_valid), .disp_ready(disp_ready),
        .busy(busy), .done(done));
    sae_fe_model u_fe (.clk(clk), .sys_rst(sys_rst), .sync_in(sync_in),
        .samp_in(samp_in), .samp_valid(samp_valid));
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Display stalls 64 of every 128 cycles so the FIFO fills and refuses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        disp_ready <= cyc[6];
        if (disp_valid && disp_ready) got.push_back(disp_data);
        if (done) n_done <= n_done + 1;
        if (chk_time && fft_valid) n_fft <= n_fft + 1;
        if (chk_time && fft_valid) cmp(16'(fft_samp), 16'(1 - fft_addr));
    end
    // Transform stand-in: bin i scaled by i+1, upper half poisoned
    initial begin : fft_model
        int i;
        fft_in = '0;
        fft_in_valid = 1'b0;
        forever begin
            for (i = 0; i < 1024; ) begin
                @(posedge clk);
                if (fft_valid) i++;
            end
            for (i = 0; i < 512; i++) begin
                fft_in_valid <= 1'b1;
                fft_in.re <= (i < 256) ? 16'(re_k * (i + 1)) : 16'h7FFF;
                fft_in.im <= (i < 256) ? 16'(im_k * (i + 1)) : 16'h7FFF;
                @(posedge clk);
            end
            fft_in_valid <= 1'b0;
        end
    end
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    // Reference log code: eight per octave plus the three bits below the leading one
    function automatic logic [15:0] log_ref(input int a);
        int p;
        p = 0;
        for (int b = 0; b < 16; b++) begin
            if (a[b]) begin
                p = b;
            end
        end
        log_ref = 16'(p * 8 + ((p >= 3) ? ((a >> (p - 3)) & 7) : 0));
    endfunction : log_ref
    task automatic end_sim;
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        got.delete();
    endtask : do_reset
    task automatic run(input sae_mode_t m, input logic [2:0] k);
        mode <= m;
        k_sel <= k;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask : run
    task automatic wait_bins(input int n);
        int t;
        for (t = 0; t < 30000 && got.size() < n; t++) @(posedge clk);
        cmp(16'(got.size()), 16'(n));
    endtask : wait_bins
    task automatic wait_done(input int n0);
        int t;
        for (t = 0; t < 30000 && n_done == n0; t++) @(posedge clk);
        cmp(16'(n_done - n0), 16'h0001);
    endtask : wait_done
    // Eight synced records averaged into one record and one transform
    task automatic test_time;
        int n0, f0;
        do_reset();
        re_k = 16'h0003;
        im_k = 16'h0004;
        n0 = n_done;
        f0 = n_fft;
        chk_time = 1'b1;
        run(SAE_MODE_TIME, 3'h1);
        wait_bins(256);
        wait_done(n0);
        chk_time = 1'b0;
        cmp(16'(n_fft - f0), 16'h0400);
    endtask : test_time
    // Four power spectra averaged: last pass shows amplitude 5*(i+1)
    task automatic test_power;
        int i, n0;
        do_reset();
        n0 = n_done;
        run(SAE_MODE_POWER, 3'h0);
        wait_bins(1024);
        wait_done(n0);
        for (i = 0; i < 256; i++) begin
            cmp(got[768 + i].value, 16'(5 * (i + 1)));
            cmp(16'(got[768 + i].bin), 16'(i));
        end
    endtask : test_power
    // Zero spectrum loads first; next pass weighs the new spectrum by a quarter
    task automatic test_exp;
        int i, t;
        do_reset();
        re_k = 16'h0000;
        im_k = 16'h0000;
        run(SAE_MODE_EXP, 3'h0);
        wait_bins(256);
        re_k = 16'h0004;
        wait_bins(512);
        // Last pass: quarter of 4 plus three quarters of 4 keeps 2*(i+1), shown as log
        re_k = 16'h0002;
        log_sel <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (t = 0; t < 20000 && busy === 1'b1; t++) @(posedge clk);
        cmp(16'(busy), 16'h0000);
        wait_bins(768);
        for (i = 0; i < 256; i++) cmp(got[256 + i].value, 16'(2 * (i + 1)));
        for (i = 0; i < 256; i++) cmp(got[512 + i].value, log_ref(2 * (i + 1)));
    endtask : test_exp
    initial begin
        start = 1'b0;
        log_sel = 1'b0;
        mode = SAE_MODE_POWER;
        k_sel = 3'h0;
        chk_time = 1'b0;
        re_k = 16'h0000;
        im_k = 16'h0000;
        test_time();
        test_power();
        test_exp();
        end_sim();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule : tb
